// ---- core/uic_irq_ctrl.sv ----
`timescale 1ns/10ps
module uic_irq_ctrl (
	input  wire logic       clk_sys,      // System clock
	input  wire logic       reset,        // Synchronous reset, active high
	input  wire logic [2:0] addr,         // Register address
	input  wire logic [7:0] wrData,       // Write data
	input  wire logic       wrStb,        // Write strobe
	input  wire logic       rdStb,        // Read strobe
	output logic      [7:0] rdData,       // Read data, cycle after strobe
	input  wire logic       rhrRead,      // Receive holding reg read
	input  wire logic       thrWrite,     // Transmit holding reg write
	input  wire logic       lsrRead,      // Line status reg read
	input  wire logic       msrRead,      // Modem status reg read
	input  wire logic       rxPush,       // Character received into queue
	input  wire logic       xoffRcvd,     // Xoff character matched
	input  wire logic       xonRcvd,      // Xon character matched
	input  wire logic       specialRcvd,  // Special character matched
	input  wire logic [3:0] lsrErrBits,   // Line status bits 1 to 4
	input  wire logic [3:0] modemDelta,   // Modem status bits 0 to 3
	input  wire logic [5:0] rxCount,      // Receive queue level
	input  wire logic [5:0] txCount,      // Transmit queue level
	input  wire logic       bitTick,      // Bit time enable pulse
	input  wire logic [3:0] charBits,     // Bits per character frame
	input  wire logic       enhancedEn,   // Enhanced functions enabled
	input  wire logic       autoCtsEn,    // Automatic clear-to-send control
	input  wire logic       autoRtsEn,    // Automatic request-to-send control
	input  wire logic       ctsPinN,      // Clear-to-send pin, asynchronous
	input  wire logic       rtsPinN,      // Request-to-send output level
	output logic            irqOut,       // Interrupt pending, active high
	output logic            fifoEnable,   // Queues enabled
	output logic            dmaMode,      // Ready pin mode
	output logic            rxFifoClr,    // Receive queue reset pulse
	output logic            txFifoClr,    // Transmit queue reset pulse
	output logic      [5:0] txTrigLevel,  // Transmit trigger level
	output logic      [5:0] rxTrigLevel,  // Receive trigger level
	output logic            txReadyPinN,  // Transmit ready pin, active low
	output logic            rxReadyPinN   // Receive ready pin, active low
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Pick highest priority pending level
	function automatic uic_pkg::uic_level_t highestLevel(input logic [7:1] pend);
		uic_pkg::uic_level_t lv;
		lv = uic_pkg::LV_NONE;
		for (int i = 7; i >= 1; i--) begin
			if (pend[i]) begin
				lv = uic_pkg::uic_level_t'(3'(i));
			end
		end
		return lv;
	endfunction

	// Map a level to its source code
	function automatic logic [5:0] levelCode(input uic_pkg::uic_level_t lv);
		logic [5:0] c;
		c = uic_pkg::CODE_NONE;
		unique case (lv)
			uic_pkg::LV_NONE:  c = uic_pkg::CODE_NONE;
			uic_pkg::LV_LSR:   c = uic_pkg::CODE_LSR;
			uic_pkg::LV_RXTO:  c = uic_pkg::CODE_RXTO;
			uic_pkg::LV_RX_READY_PIN_N: c = uic_pkg::CODE_RX_READY_PIN_N;
			uic_pkg::LV_TX_READY_PIN_N: c = uic_pkg::CODE_TX_READY_PIN_N;
			uic_pkg::LV_MSR:   c = uic_pkg::CODE_MSR;
			uic_pkg::LV_XOFF:  c = uic_pkg::CODE_XOFF;
			uic_pkg::LV_FLOW:  c = uic_pkg::CODE_FLOW;
		endcase
		return c;
	endfunction

	// ----------------------------------------
	// State, decode terms and timer link
	// ----------------------------------------
	logic [7:0]          ier_q, ier_d;              // Irq enable reg
	logic                fifoEn_q, fifoEn_d;        // Queues enabled
	logic                dma_q, dma_d;              // Ready pin mode
	logic                rxClr_q, rxClr_d;          // Receive reset pulse
	logic                txClr_q, txClr_d;          // Transmit reset pulse
	logic [5:0]          txTrig_q, txTrig_d;        // Transmit trigger level
	logic [5:0]          rxTrig_q, rxTrig_d;        // Receive trigger level
	logic [7:0]          rdData_q, rdData_d;        // Read data
	uic_pkg::uic_level_t cur_q, cur_d;              // Reported source
	logic                irq_q, irq_d;              // Interrupt output
	logic                lsrFlag_q, lsrFlag_d;      // Line status pending
	logic                msrFlag_q, msrFlag_d;      // Modem status pending
	logic                toFlag_q, toFlag_d;        // Receive timeout pending
	logic                txFlag_q, txFlag_d;        // Transmit ready pending
	logic                xoffFlag_q, xoffFlag_d;    // Xoff pending
	logic                specFlag_q, specFlag_d;    // Special character pending
	logic                flowFlag_q, flowFlag_d;    // Flow pin change pending
	logic                lsrAny_q, msrAny_q;        // Previous error/delta levels
	logic [5:0]          txPrev_q;                  // Previous transmit level
	logic                txAbove_q, txAbove_d;      // Reload went above trigger
	logic [2:0]          ctsSync_q;                 // Clear-to-send synchroniser
	logic                ctsLvl_q, ctsLvl_d;        // Filtered pin level
	logic                rtsPrev_q;                 // Previous request-to-send level
	logic                txRdyN_q, txRdyN_d;        // Transmit ready pin
	logic                rxRdyN_q, rxRdyN_d;        // Receive ready pin

	logic            ierWr, qcWr, ierRd, srcRd;   // Register accesses
	logic            enh;                         // Enhanced mode
	logic [5:0]      txTrigEff;                   // Trigger in force
	logic            rxLevelHit;                  // Receive level reached
	logic            txSet, txClear;              // Transmit flag events
	logic            ctsRise, rtsRise;            // Pin rising edges
	logic [7:1]      pend;                        // Pending by level
	logic [5:0]      curCode;                     // Reported code
	uic_timer_if     tif ();                      // Timer link

	assign enh   = enhancedEn;
	assign ierWr = wrStb && addr == uic_pkg::ADDR_IRQ_EN;
	assign qcWr  = wrStb && addr == uic_pkg::ADDR_IRQ_SRC;
	assign ierRd = rdStb && addr == uic_pkg::ADDR_IRQ_EN;
	assign srcRd = rdStb && addr == uic_pkg::ADDR_IRQ_SRC;

	assign tif.bitTick    = bitTick;
	assign tif.charBits   = charBits;
	assign tif.rxPush     = rxPush;
	assign tif.rhrRead    = rhrRead;
	assign tif.rxNotEmpty = rxCount != 6'h00;
	assign tif.fifoEn     = fifoEn_q;

	uic_rx_timer uTimer (
		.clk_sys (clk_sys),
		.reset   (reset),
		.tif     (tif.timer)
	);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_comb begin
		ier_d    = ier_q;
		fifoEn_d = fifoEn_q;
		dma_d    = dma_q;
		txTrig_d = txTrig_q;
		rxTrig_d = rxTrig_q;
		rxClr_d  = 1'b0;
		txClr_d  = 1'b0;
		if (ierWr) begin
			// Upper bits keep their value outside enhanced mode
			ier_d = enh ? wrData : (wrData & uic_pkg::IE_LOW_MASK)
			                       | (ier_q & ~uic_pkg::IE_LOW_MASK);
		end
		if (qcWr) begin
			// other bits only with enable set
			fifoEn_d = wrData[uic_pkg::QC_EN];
			if (wrData[uic_pkg::QC_EN]) begin
				rxClr_d = wrData[uic_pkg::QC_RX_CLR];
				txClr_d = wrData[uic_pkg::QC_TX_CLR];
				dma_d = wrData[uic_pkg::QC_DMA];
				if (enh) begin
					unique case (wrData[uic_pkg::QC_TX_LSB +: 2])
						2'b00: txTrig_d = uic_pkg::TX_TRIG_0;
						2'b01: txTrig_d = uic_pkg::TX_TRIG_1;
						2'b10: txTrig_d = uic_pkg::TX_TRIG_2;
						2'b11: txTrig_d = uic_pkg::TX_TRIG_3;
					endcase
				end
				unique case (wrData[uic_pkg::QC_RX_LSB +: 2])
					2'b00: rxTrig_d = uic_pkg::RX_TRIG_0;
					2'b01: rxTrig_d = uic_pkg::RX_TRIG_1;
					2'b10: rxTrig_d = uic_pkg::RX_TRIG_2;
					2'b11: rxTrig_d = uic_pkg::RX_TRIG_3;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Pin edges and source flags
	// ----------------------------------------
	always_comb begin
		// Accept a change once stages two and three agree
		ctsLvl_d = (ctsSync_q[1] == ctsSync_q[2]) ? ctsSync_q[2] : ctsLvl_q;
	end

	// rising pins during automatic flow control
	assign ctsRise = ctsLvl_d && !ctsLvl_q && autoCtsEn && ier_q[uic_pkg::IE_CTS];
	assign rtsRise = rtsPinN && !rtsPrev_q && autoRtsEn && ier_q[uic_pkg::IE_RTS];

	assign txTrigEff  = fifoEn_q ? txTrig_q : uic_pkg::NOFIFO_TRIG;
	// receive level interrupt follows queue level
	assign rxLevelHit = fifoEn_q ? (rxCount >= rxTrig_q) : (rxCount != 6'h00);
	assign curCode    = levelCode(cur_q);

	// below trigger, or empty after short reload
	assign txSet = (txPrev_q >= txTrigEff && txCount < txTrigEff && txAbove_q)
	            || (txPrev_q != 6'h00 && txCount == 6'h00 && !txAbove_q)
	            || (ierWr && wrData[uic_pkg::IE_TX] && !ier_q[uic_pkg::IE_TX]
	                && txCount == 6'h00);
	// source read or holding reg write
	assign txClear = (srcRd && cur_q == uic_pkg::LV_TX_READY_PIN_N) || thrWrite;

	always_comb begin
		// Set always wins over a clear in the same cycle
		// error rising raises, line read clears
		lsrFlag_d  = (|lsrErrBits && !lsrAny_q) || (lsrFlag_q && !lsrRead);
		// delta rising raises, modem read clears
		msrFlag_d  = (|modemDelta && !msrAny_q) || (msrFlag_q && !msrRead);
		toFlag_d   = tif.expire || (toFlag_q && !rhrRead);
		txFlag_d   = txSet || (txFlag_q && !txClear);
		// Xoff cleared by read or Xon
		xoffFlag_d = (xoffRcvd && enh && ier_q[uic_pkg::IE_XOFF])
		          || (xoffFlag_q && !xonRcvd
		              && !(srcRd && cur_q == uic_pkg::LV_XOFF));
		// special cleared by read or next char
		specFlag_d = (specialRcvd && enh && ier_q[uic_pkg::IE_XOFF])
		          || (specFlag_q && !rxPush
		              && !(srcRd && cur_q == uic_pkg::LV_XOFF));
		flowFlag_d = (enh && (ctsRise || rtsRise)) || (flowFlag_q && !msrRead);
		// Track reload above trigger for empty fallback
		txAbove_d = !txSet && (txAbove_q || (txCount > txTrigEff));
	end

	// ----------------------------------------
	// Priority, read data and ready pins
	// ----------------------------------------
	always_comb begin
		pend[1] = lsrFlag_q && ier_q[uic_pkg::IE_LSR];
		pend[2] = toFlag_q && ier_q[uic_pkg::IE_RX];
		pend[3] = rxLevelHit && ier_q[uic_pkg::IE_RX];
		pend[4] = txFlag_q && ier_q[uic_pkg::IE_TX];
		pend[5] = msrFlag_q && ier_q[uic_pkg::IE_MSR];
		// bits four and five only here
		pend[6] = (xoffFlag_q || specFlag_q) && enh;
		pend[7] = flowFlag_q && enh;
		// keep current source until it clears
		if (cur_q == uic_pkg::LV_NONE || !pend[cur_q]) begin
			cur_d = highestLevel(pend);
		end else begin
			cur_d = cur_q;
		end
		irq_d = cur_d != uic_pkg::LV_NONE;
	end

	// Read data and ready pin levels
	always_comb begin
		rdData_d = 8'h00;
		if (ierRd) begin
			rdData_d = ier_q;
		end else if (srcRd) begin
			// queue enable copies in bits seven, six
			// level codes in bits five to zero
			rdData_d = {fifoEn_q, fifoEn_q, curCode};
		end
		// normal mode versus block transfer mode
		if (dma_q && fifoEn_q) begin
			rxRdyN_d = !(rxLevelHit || toFlag_q);
			txRdyN_d = txCount == uic_pkg::FIFO_DEPTH;
		end else begin
			rxRdyN_d = rxCount == 6'h00;
			txRdyN_d = txCount != 6'h00;
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ier_q      <= uic_pkg::IE_RESET;
			fifoEn_q   <= 1'b0;
			dma_q      <= 1'b0;
			rxClr_q    <= 1'b0;
			txClr_q    <= 1'b0;
			txTrig_q   <= uic_pkg::TX_TRIG_0;
			rxTrig_q   <= uic_pkg::RX_TRIG_0;
			rdData_q   <= 8'h00;
			cur_q      <= uic_pkg::LV_NONE;
			irq_q      <= 1'b0;
			lsrFlag_q  <= 1'b0;
			msrFlag_q  <= 1'b0;
			toFlag_q   <= 1'b0;
			txFlag_q   <= 1'b0;
			xoffFlag_q <= 1'b0;
			specFlag_q <= 1'b0;
			flowFlag_q <= 1'b0;
			lsrAny_q   <= 1'b0;
			msrAny_q   <= 1'b0;
			txPrev_q   <= 6'h00;
			txAbove_q  <= 1'b0;
			ctsSync_q  <= 3'h7;
			ctsLvl_q   <= 1'b1;
			rtsPrev_q  <= 1'b1;
			txRdyN_q   <= 1'b0;
			rxRdyN_q   <= 1'b1;
		end else begin
			ier_q      <= ier_d;
			fifoEn_q   <= fifoEn_d;
			dma_q      <= dma_d;
			rxClr_q    <= rxClr_d;
			txClr_q    <= txClr_d;
			txTrig_q   <= txTrig_d;
			rxTrig_q   <= rxTrig_d;
			rdData_q   <= rdData_d;
			cur_q      <= cur_d;
			irq_q      <= irq_d;
			lsrFlag_q  <= lsrFlag_d;
			msrFlag_q  <= msrFlag_d;
			toFlag_q   <= toFlag_d;
			txFlag_q   <= txFlag_d;
			xoffFlag_q <= xoffFlag_d;
			specFlag_q <= specFlag_d;
			flowFlag_q <= flowFlag_d;
			lsrAny_q   <= |lsrErrBits;
			msrAny_q   <= |modemDelta;
			txPrev_q   <= txCount;
			txAbove_q  <= txAbove_d;
			ctsSync_q  <= {ctsSync_q[1:0], ctsPinN};
			ctsLvl_q   <= ctsLvl_d;
			rtsPrev_q  <= rtsPinN;
			txRdyN_q   <= txRdyN_d;
			rxRdyN_q   <= rxRdyN_d;
		end
	end

	// Outputs straight from registers
	assign rdData      = rdData_q;
	assign irqOut      = irq_q;
	assign fifoEnable  = fifoEn_q;
	assign dmaMode     = dma_q;
	assign rxFifoClr   = rxClr_q;
	assign txFifoClr   = txClr_q;
	assign txTrigLevel = txTrig_q;
	assign rxTrigLevel = rxTrig_q;
	assign txReadyPinN = txRdyN_q;
	assign rxReadyPinN = rxRdyN_q;

endmodule // uic_irq_ctrl

// ---- core/uic_pkg.sv ----
package uic_pkg;

	// ----------------------------------------
	// Register offsets on the local port
	// ----------------------------------------
	localparam logic [2:0] ADDR_IRQ_EN  = 3'h1;     // Irq enable reg, read/write
	localparam logic [2:0] ADDR_IRQ_SRC = 3'h2;     // Read: irq source reg, write: queue control

	// ----------------------------------------
	// Irq enable reg fields
	// ----------------------------------------
	localparam int         IE_RX       = 0;         // Receive data and timeout
	localparam int         IE_TX       = 1;         // Transmit ready
	localparam int         IE_LSR      = 2;         // Receiver line status
	localparam int         IE_MSR      = 3;         // Modem status
	localparam int         IE_XOFF     = 5;         // Xoff or special character
	localparam int         IE_RTS      = 6;         // Request-to-send rising
	localparam int         IE_CTS      = 7;         // Clear-to-send rising
	localparam logic [7:0] IE_LOW_MASK = 8'h0F;     // Bits writable without enhanced mode
	localparam logic [7:0] IE_RESET    = 8'h00;     // All sources disabled

	// ----------------------------------------
	// Queue control reg fields
	// ----------------------------------------
	localparam int QC_EN     = 0;                   // Both queues enabled
	localparam int QC_RX_CLR = 1;                   // Receive queue pointer reset
	localparam int QC_TX_CLR = 2;                   // Transmit queue pointer reset
	localparam int QC_DMA    = 3;                   // Ready pin mode
	localparam int QC_TX_LSB = 4;                   // Transmit trigger select [5:4]
	localparam int QC_RX_LSB = 6;                   // Receive trigger select [7:6]

	// ----------------------------------------
	// Source codes, bits [5:0]
	// ----------------------------------------
	localparam logic [5:0] CODE_LSR   = 6'h06;      // Level 1
	localparam logic [5:0] CODE_RXTO  = 6'h0C;      // Level 2
	localparam logic [5:0] CODE_RX_READY_PIN_N = 6'h04;      // Level 3
	localparam logic [5:0] CODE_TX_READY_PIN_N = 6'h02;      // Level 4
	localparam logic [5:0] CODE_MSR   = 6'h00;      // Level 5
	localparam logic [5:0] CODE_XOFF  = 6'h10;      // Level 6
	localparam logic [5:0] CODE_FLOW  = 6'h20;      // Level 7
	localparam logic [5:0] CODE_NONE  = 6'h01;      // Nothing pending, reset value

	// ----------------------------------------
	// Trigger levels and queue depth
	// ----------------------------------------
	localparam logic [5:0] TX_TRIG_0  = 6'h10;      // 16
	localparam logic [5:0] TX_TRIG_1  = 6'h08;      // 8
	localparam logic [5:0] TX_TRIG_2  = 6'h18;      // 24
	localparam logic [5:0] TX_TRIG_3  = 6'h1E;      // 30
	localparam logic [5:0] RX_TRIG_0  = 6'h08;      // 8
	localparam logic [5:0] RX_TRIG_1  = 6'h10;      // 16
	localparam logic [5:0] RX_TRIG_2  = 6'h18;      // 24
	localparam logic [5:0] RX_TRIG_3  = 6'h1C;      // 28
	localparam logic [5:0] NOFIFO_TRIG = 6'h01;     // Single holding register
	localparam logic [5:0] FIFO_DEPTH = 6'h20;      // 32 entries

	// ----------------------------------------
	// Receive timeout: chars times bits plus extra bits
	// ----------------------------------------
	localparam logic [7:0] TO_CHARS      = 8'h04;   // Character times
	localparam logic [7:0] TO_EXTRA_BITS = 8'h0C;   // Extra bit times

	// Priority levels, 1 is highest
	typedef enum logic [2:0] {
		LV_NONE  = 3'b000,
		LV_LSR   = 3'b001,
		LV_RXTO  = 3'b010,
		LV_RX_READY_PIN_N = 3'b011,
		LV_TX_READY_PIN_N = 3'b100,
		LV_MSR   = 3'b101,
		LV_XOFF  = 3'b110,
		LV_FLOW  = 3'b111
	} uic_level_t;

endpackage

// ---- core/uic_timer_if.sv ----
`timescale 1ns/10ps
// Links the controller to its receive timeout timer
interface uic_timer_if;
	logic       bitTick;      // One bit time elapsed
	logic [3:0] charBits;     // Bits per character frame
	logic       rxPush;       // Character entered receive queue
	logic       rhrRead;      // Receive holding reg read
	logic       rxNotEmpty;   // Receive queue holds data
	logic       fifoEn;       // Queues enabled
	logic       expire;       // Timeout reached, one cycle

	modport ctrl  (output bitTick, charBits, rxPush, rhrRead, rxNotEmpty, fifoEn,
	               input expire);
	modport timer (input bitTick, charBits, rxPush, rhrRead, rxNotEmpty, fifoEn,
	               output expire);
endinterface

// ---- core/uic_rx_timer.sv ----
`timescale 1ns/10ps
module uic_rx_timer (
	input  wire logic   clk_sys,   // System clock
	input  wire logic   reset,     // Synchronous reset, active high
	uic_timer_if.timer  tif        // Timer link
);

	logic [7:0] cnt_q;            // Bit times since last activity
	logic [7:0] cnt_d;            // Next count
	logic       expire_q;         // Timeout pulse
	logic       expire_d;         // Next pulse
	logic [7:0] limit;            // Four characters plus twelve bits

	// ----------------------------------------
	// Delay limit from frame length
	// ----------------------------------------
	assign limit = 8'(uic_pkg::TO_CHARS * {4'h0, tif.charBits}) + uic_pkg::TO_EXTRA_BITS;

	// Count bit times while data waits untouched
	always_comb begin
		cnt_d    = cnt_q;
		expire_d = 1'b0;
		if (tif.rxPush || tif.rhrRead || !tif.rxNotEmpty || !tif.fifoEn) begin
			// Any activity or empty queue restarts the delay
			cnt_d = 8'h00;
		end else if (tif.bitTick && cnt_q != limit) begin
			cnt_d = cnt_q + 8'h01;
			// Fire once when the limit is reached
			expire_d = (cnt_q + 8'h01 == limit);
		end
	end

	// Register count and pulse
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_q    <= 8'h00;
			expire_q <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			expire_q <= expire_d;
		end
	end

	assign tif.expire = expire_q;

endmodule // uic_rx_timer

// ---- tb/uic_host_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Host processor on the register port
// ----------------------------------------
module uic_host_model (
	input  wire logic       clk_sys,        // System clock
	output logic      [2:0] addr   = 3'h0,  // Register address
	output logic      [7:0] wrData = 8'h00, // Write data
	output logic            wrStb  = 1'b0,  // Write strobe
	output logic            rdStb  = 1'b0   // Read strobe
);
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr   <= a;
		wrData <= d;
		wrStb  <= 1'b1;
		@(posedge clk_sys);
		wrStb  <= 1'b0;
	endtask
	// One cycle read strobe
	task automatic rd(input logic [2:0] a);
		@(posedge clk_sys);
		addr  <= a;
		rdStb <= 1'b1;
		@(posedge clk_sys);
		rdStb <= 1'b0;
	endtask
endmodule // uic_host_model

// ---- tb/uic_irq_ctrl_checker.sv ----
`timescale 1ns/10ps
module uic_irq_ctrl_checker (
	input wire logic       clk_sys,     // System clock
	input wire logic       reset,       // Synchronous reset
	input wire logic [2:0] addr,        // Register address
	input wire logic [7:0] wrData,      // Write data
	input wire logic       wrStb,       // Write strobe
	input wire logic       rdStb,       // Read strobe
	input wire logic [7:0] rdData,      // Read data
	input wire logic       enhancedEn,  // Enhanced mode
	input wire logic       irqOut,      // Interrupt pending
	input wire logic       fifoEnable,  // Queues enabled
	input wire logic       rxFifoClr,   // Rx reset pulse
	input wire logic       txFifoClr,   // Tx reset pulse
	input wire logic [5:0] txTrigLevel  // Tx trigger
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Control write and source read
	sequence qcWr; wrStb && addr == uic_pkg::ADDR_IRQ_SRC; endsequence
	sequence srcRd; rdStb && addr == uic_pkg::ADDR_IRQ_SRC; endsequence
	unmapped_zero_a: assert property (
		rdStb && addr != 3'h1 && addr != 3'h2 |=> rdData == 8'h00) else $error("unmapped read");
	pend_flag_a: assert property (
		srcRd |=> rdData[0] == !$past(irqOut)) else $error("pending bit wrong");
	fifo_bits_a: assert property (
		srcRd |=> rdData[7:6] == {2{$past(fifoEnable)}}) else $error("fifo bits wrong");
	code_legal_a: assert property (
		srcRd |=> rdData[5:0] inside {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
		else $error("illegal code");
	rx_pulse_a: assert property (
		qcWr ##0 (wrData[0] && wrData[1]) |=> rxFifoClr ##1 !rxFifoClr) else $error("rx clr");
	tx_pulse_a: assert property (
		txFifoClr |-> $past(wrStb && addr == 3'h2 && wrData[0] && wrData[2])) else $error("tx clr");
	fifo_en_a: assert property (
		qcWr |=> fifoEnable == $past(wrData[0])) else $error("fifo enable wrong");
	fifo_hold_a: assert property (
		!$past(wrStb && addr == 3'h2) |-> $stable(fifoEnable)) else $error("fifo enable moved");
	tx_trig_lock_a: assert property (
		qcWr ##0 (!enhancedEn && wrData[0] && fifoEnable) |=> $stable(txTrigLevel))
		else $error("tx trigger moved");
endmodule // uic_irq_ctrl_checker
bind uic_irq_ctrl uic_irq_ctrl_checker chk (.clk_sys(clk_sys), .reset(reset), .addr(addr),
	.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .enhancedEn(enhancedEn),
	.irqOut(irqOut), .fifoEnable(fifoEnable), .rxFifoClr(rxFifoClr), .txFifoClr(txFifoClr),
	.txTrigLevel(txTrigLevel));

// ---- tb/uic_irq_ctrl_tb.sv ----
`timescale 1ns/10ps
module uic_irq_ctrl_tb;
	logic       clk_sys = 1'b0, reset = 1'b1, rdPend = 1'b0;     // Clock, reset, read pending
	logic       wrStb, rdStb, irqOut, fifoEnable, dmaMode;       // Strobes and status
	logic       enhancedEn = 1'b0, autoRtsEn = 1'b0, rtsPinN = 1'b0; // Mode levels
	logic bitTick = 1'b0, autoCtsEn = 1'b0, ctsPinN = 1'b0, txReadyPinN, rxReadyPinN; // Tick, pins
	logic [2:0] addr;                                            // Register address
	logic [7:0] wrData, rdData, rnd, pv = 8'h00;                 // Bus data and event pulses
	logic [3:0] lsrErrBits = 4'h0, modemDelta = 4'h0;            // Status levels
	logic [5:0] rxCount = 6'h00, txCount = 6'h00, txTrigLevel, rxTrigLevel; // Queue levels
	logic [5:0] txTab [4] = '{uic_pkg::TX_TRIG_0, uic_pkg::TX_TRIG_1, uic_pkg::TX_TRIG_2,
		uic_pkg::TX_TRIG_3};                                     // Tx trigger table
	logic [5:0] rxTab [4] = '{uic_pkg::RX_TRIG_0, uic_pkg::RX_TRIG_1, uic_pkg::RX_TRIG_2,
		uic_pkg::RX_TRIG_3};                                     // Rx trigger table
	logic [7:0] expQ [$];                                        // Expected read data
	int         fails = 0, checks = 0, seed = 32'h2c84_e38b;     // Counters and seed
	uic_host_model host (.clk_sys, .addr, .wrData, .wrStb, .rdStb);
	uic_irq_ctrl uut (.clk_sys, .reset, .addr, .wrData, .wrStb, .rdStb, .rdData,
		.rhrRead(pv[3]), .thrWrite(pv[4]), .lsrRead(pv[0]), .msrRead(pv[1]), .rxPush(pv[5]),
		.xoffRcvd(pv[2]), .xonRcvd(pv[6]), .specialRcvd(pv[7]), .lsrErrBits, .modemDelta,
		.rxCount, .txCount, .bitTick, .charBits(4'hA), .enhancedEn, .autoCtsEn,
		.autoRtsEn, .ctsPinN, .rtsPinN, .irqOut, .fifoEnable, .dmaMode, .rxFifoClr(),
		.txFifoClr(), .txTrigLevel, .rxTrigLevel, .txReadyPinN, .rxReadyPinN);
	// Clock and watchdog
	initial forever #2.5 clk_sys = ~clk_sys;
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		end_sim();
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdx(input logic [2:0] a, input logic [7:0] e);
		expQ.push_back(e);
		host.rd(a);
	endtask
	// One cycle event pulse, then settle
	task automatic pul(input int b);
		@(posedge clk_sys);
		pv[b] <= 1'b1;
		@(posedge clk_sys);
		pv <= 8'h00;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic src(input logic [5:0] c);
		repeat (3) @(posedge clk_sys);
		rdx(uic_pkg::ADDR_IRQ_SRC, {2'b11, c});
	endtask
	task automatic end_sim();
		$display("Counts: checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Read data monitor takes oldest note
	always @(posedge clk_sys) begin
		if (rdPend) chk(rdData, expQ.pop_front());
		rdPend <= rdStb;
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		chk({6'h00, rxReadyPinN, txReadyPinN}, 8'h02);
		rdx(uic_pkg::ADDR_IRQ_SRC, {2'b00, uic_pkg::CODE_NONE});
		rdx(3'h0, 8'h00);
		rnd = 8'($random(seed)) & 8'hFD;
		host.wr(uic_pkg::ADDR_IRQ_EN, rnd);
		rdx(uic_pkg::ADDR_IRQ_EN, {4'h0, rnd[3:0]});
		enhancedEn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			host.wr(uic_pkg::ADDR_IRQ_SRC, {i[1:0], i[1:0], i[0], i[1], i[1], 1'b1});
			@(posedge clk_sys);
			chk({2'b00, txTrigLevel}, {2'b00, txTab[i]});
			chk({2'b00, rxTrigLevel}, {2'b00, rxTab[i]});
			chk({7'h00, dmaMode}, {7'h00, i[0]});
		end
		enhancedEn <= 1'b0;
		host.wr(uic_pkg::ADDR_IRQ_SRC, 8'h01);
		@(posedge clk_sys);
		chk({2'b00, txTrigLevel}, {2'b00, txTab[3]});
		host.wr(uic_pkg::ADDR_IRQ_SRC, 8'hC6);
		rdx(uic_pkg::ADDR_IRQ_SRC, {2'b00, uic_pkg::CODE_NONE});
		host.wr(uic_pkg::ADDR_IRQ_SRC, 8'h01);
		$display("Test queue control done");
		host.wr(uic_pkg::ADDR_IRQ_EN, 8'h0D);
		rxCount <= 6'h08;
		src(uic_pkg::CODE_RX_READY_PIN_N);
		rxCount <= 6'h07;
		src(uic_pkg::CODE_NONE);
		bitTick <= 1'b1;
		repeat (40) @(posedge clk_sys);
		src(uic_pkg::CODE_NONE);
		repeat (20) @(posedge clk_sys);
		bitTick <= 1'b0;
		src(uic_pkg::CODE_RXTO);
		chk({6'h00, rxReadyPinN, txReadyPinN}, 8'h00);
		host.wr(uic_pkg::ADDR_IRQ_SRC, 8'h09);
		repeat (2) @(posedge clk_sys);
		chk({6'h00, rxReadyPinN, txReadyPinN}, 8'h00);
		pul(3);
		src(uic_pkg::CODE_NONE);
		chk({6'h00, rxReadyPinN, txReadyPinN}, 8'h02);
		lsrErrBits <= 4'h1;
		modemDelta <= 4'h8;
		src(uic_pkg::CODE_LSR);
		src(uic_pkg::CODE_LSR);
		pul(0);
		src(uic_pkg::CODE_MSR);
		pul(1);
		src(uic_pkg::CODE_NONE);
		host.wr(uic_pkg::ADDR_IRQ_EN, 8'h0F);
		src(uic_pkg::CODE_TX_READY_PIN_N);
		src(uic_pkg::CODE_NONE);
		$display("Test priority done");
		enhancedEn <= 1'b1;
		autoRtsEn <= 1'b1;
		host.wr(uic_pkg::ADDR_IRQ_EN, 8'hEF);
		pul(2);
		src(uic_pkg::CODE_XOFF);
		src(uic_pkg::CODE_NONE);
		rtsPinN <= 1'b1;
		src(uic_pkg::CODE_FLOW);
		src(uic_pkg::CODE_FLOW);
		pul(1);
		src(uic_pkg::CODE_NONE);
		autoCtsEn <= 1'b1;
		ctsPinN <= 1'b1;
		repeat (3) @(posedge clk_sys);
		src(uic_pkg::CODE_FLOW);
		pul(1);
		src(uic_pkg::CODE_NONE);
		repeat (4) @(posedge clk_sys);
		if (expQ.size() != 0) fails++;
		$display("Test enhanced sources done");
		end_sim();
	end
endmodule // uic_irq_ctrl_tb
